// file: inc/cgr_pkg.sv
// Constants and types for the clock generator control register bank
package cgr_pkg;

    // ****************************************
    // Serial port
    // ****************************************
    localparam logic [6:0] SLAVE_ADDR     = 7'h69;
    localparam int         CMD_SINGLE_BIT = 7;

    // ****************************************
    // Register indices
    // ****************************************
    localparam int REG_COUNT   = 13;
    localparam int IDX_PROFILE = 1;
    localparam int IDX_ENABLE  = 4;
    localparam int IDX_IDENT   = 7;
    localparam int IDX_PART    = 8;
    localparam int IDX_TEST    = 9;
    localparam int IDX_COMPLY  = 11;
    localparam int IDX_COUNT   = 12;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PROFILE_BIT    = 6;
    localparam int OE1_BIT        = 6;
    localparam int OE2_BIT        = 5;
    localparam int OE3_BIT        = 3;
    localparam int OE4_BIT        = 2;
    localparam int SPREAD_EN_BIT  = 1;
    localparam int TEST_SEL_BIT   = 4;
    localparam int TEST_ENTRY_BIT = 3;
    localparam int SWING_MSB      = 2;
    localparam int COMPLY_BIT     = 1;

    // ****************************************
    // Identity codes, values arbitrary
    // ****************************************
    localparam logic [3:0] REV_CODE   = 4'h1;
    localparam logic [3:0] MAKER_CODE = 4'h2;
    localparam logic [3:0] PART_CODE  = 4'h5;

    // ****************************************
    // Power-up values and writable bits
    // ****************************************
    localparam logic [7:0] RESET_VALUE [REG_COUNT] = '{
        8'h21, 8'h85, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00,
        {REV_CODE, MAKER_CODE}, {PART_CODE, 4'h3},
        8'h25, 8'h03, 8'h07, 8'h0E};
    localparam logic [7:0] WRITE_MASK [REG_COUNT] = '{
        8'h00, 8'h40, 8'h00, 8'h00, 8'h6E, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'hFF};

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX_BYTE, ST_RX_ACK, ST_TX_BYTE, ST_TX_ACK, ST_IGNORE
    } cgr_state_type;

    typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA} cgr_phase_type;

endpackage

// file: hw/cgr_pin_sync.sv
// Two-stage synchronisers for the serial clock and data pins
`timescale 1ns/1ps
module cgr_pin_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Raw pins
    input  wire logic sclPin,
    input  wire logic sdaPin,
    // Synchronised levels
    output logic      sclSync,
    output logic      sdaSync
);
    logic [1:0] stage1;
    logic [1:0] next_stage1;
    logic [1:0] next_stage2;

    always_comb begin
        next_stage1 = {sclPin, sdaPin};
        next_stage2 = stage1;
    end

    // Idle bus is high, so reset to high
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stage1  <= 2'h3;
            sclSync <= 1'b1;
            sdaSync <= 1'b1;
        end else begin
            stage1  <= next_stage1;
            sclSync <= next_stage2[1];
            sdaSync <= next_stage2[0];
        end
    end
endmodule

// file: hw/cgr_ctrl_regs.sv
// Control register bank with two-wire serial slave port
`timescale 1ns/1ps
module cgr_ctrl_regs
    import cgr_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Serial pins, data is open drain
    input  wire logic       sclPin,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOeN,
    // Clock generator controls
    output logic [3:0]      refoutEnable,
    output logic            spreadModulationEnable,
    output logic            spreadProfileSelect,
    output logic            testModeSelect,
    output logic            testModeEntry,
    output logic [2:0]      outputSwingCode,
    output logic            secondGenCompliant
);

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic sclSync, sdaSync;
    logic sclPrev, sdaPrev;
    logic sclRise, sclFall;
    logic startCond, stopCond;

    cgr_pin_sync cgr_pin_sync_inst (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .sclPin  (sclPin),
        .sdaPin  (sdaIn),
        .sclSync (sclSync),
        .sdaSync (sdaSync)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclSync;
            sdaPrev <= sdaSync;
        end
    end

    assign sclRise   = sclSync & ~sclPrev;
    assign sclFall   = ~sclSync & sclPrev;
    assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
    assign stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;

    // ****************************************
    // State
    // ****************************************
    cgr_state_type state, next_state;
    cgr_phase_type phase, next_phase;
    logic [2:0]    bitCnt, next_bitCnt;
    logic [7:0]    shiftReg, next_shiftReg;
    logic          byteDone, next_byteDone;
    logic          readMode, next_readMode;
    logic          blockMode, next_blockMode;
    logic          countSeen, next_countSeen;
    logic [6:0]    ptr, next_ptr;
    logic [7:0]    sentCnt, next_sentCnt;
    logic          acked, next_acked;
    logic          next_sdaOeN;
    logic [7:0]    regs [REG_COUNT], next_regs [REG_COUNT];
    logic          wrEn, txMore;
    logic [7:0]    txData;

    function automatic logic [7:0] readByte(input logic [6:0] idx);
        readByte = (idx < 7'(REG_COUNT)) ? regs[idx[3:0]] : 8'h00;
    endfunction

    // Next byte to send; count byte leads a block read
    always_comb begin
        if (blockMode && !countSeen) begin
            txData = regs[IDX_COUNT];
        end else begin
            txData = readByte(ptr);
        end
        txMore = blockMode && (!countSeen || sentCnt < regs[IDX_COUNT]);
    end

    // ****************************************
    // Serial protocol and register update
    // ****************************************
    always_comb begin
        next_state     = state;
        next_phase     = phase;
        next_bitCnt    = bitCnt;
        next_shiftReg  = shiftReg;
        next_byteDone  = byteDone;
        next_readMode  = readMode;
        next_blockMode = blockMode;
        next_countSeen = countSeen;
        next_ptr       = ptr;
        next_sentCnt   = sentCnt;
        next_acked     = acked;
        next_sdaOeN    = sdaOeN;
        next_regs      = regs;
        wrEn           = 1'b0;
        if (stopCond) begin
            next_state  = ST_IDLE;
            next_sdaOeN = 1'b1;
        end else if (startCond) begin
            // Repeated start keeps pointer and mode
            next_state    = ST_RX_BYTE;
            next_phase    = PH_ADDR;
            next_bitCnt   = 3'h0;
            next_byteDone = 1'b0;
            next_sdaOeN   = 1'b1;
        end else begin
            unique case (state)
                ST_RX_BYTE: begin
                    if (sclRise && !byteDone) begin
                        next_shiftReg = {shiftReg[6:0], sdaSync};
                        next_bitCnt   = bitCnt + 3'h1;
                        next_byteDone = (bitCnt == 3'h7);
                    end else if (sclFall && byteDone) begin
                        next_byteDone = 1'b0;
                        next_state    = ST_RX_ACK;
                        next_sdaOeN   = 1'b0;
                        unique case (phase)
                            PH_ADDR: begin
                                if (shiftReg[7:1] == SLAVE_ADDR) begin
                                    next_readMode = shiftReg[0];
                                    next_phase    = shiftReg[0] ? PH_DATA : PH_CMD;
                                    next_sentCnt  = 8'h00;
                                end else begin
                                    next_state  = ST_IGNORE;
                                    next_sdaOeN = 1'b1;
                                end
                            end
                            PH_CMD: begin
                                next_blockMode = ~shiftReg[CMD_SINGLE_BIT];
                                next_ptr       = shiftReg[CMD_SINGLE_BIT] ?
                                                 shiftReg[6:0] : 7'h00;
                                next_countSeen = 1'b0;
                                next_phase     = PH_DATA;
                            end
                            PH_DATA: begin
                                if (blockMode && !countSeen) begin
                                    // Write count byte carries no data
                                    next_countSeen = 1'b1;
                                end else begin
                                    wrEn     = 1'b1;
                                    next_ptr = ptr + 7'h01;
                                end
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    if (sclFall) begin
                        next_bitCnt = 3'h0;
                        if (readMode) begin
                            next_state    = ST_TX_BYTE;
                            next_shiftReg = txData;
                            next_sdaOeN   = txData[7];
                            if (blockMode && !countSeen) begin
                                next_countSeen = 1'b1;
                            end else begin
                                next_ptr     = ptr + 7'h01;
                                next_sentCnt = sentCnt + 8'h01;
                            end
                        end else begin
                            next_state  = ST_RX_BYTE;
                            next_sdaOeN = 1'b1;
                        end
                    end
                end
                ST_TX_BYTE: begin
                    if (sclFall) begin
                        next_bitCnt = bitCnt + 3'h1;
                        if (bitCnt == 3'h7) begin
                            next_state  = ST_TX_ACK;
                            next_sdaOeN = 1'b1;
                        end else begin
                            next_shiftReg = {shiftReg[6:0], 1'b0};
                            next_sdaOeN   = shiftReg[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (sclRise) begin
                        next_acked = ~sdaSync;
                    end else if (sclFall) begin
                        // Host may stop after any complete byte
                        if (acked && txMore) begin
                            next_state    = ST_TX_BYTE;
                            next_bitCnt   = 3'h0;
                            next_shiftReg = txData;
                            next_sdaOeN   = txData[7];
                            if (!countSeen) begin
                                next_countSeen = 1'b1;
                            end else begin
                                next_ptr     = ptr + 7'h01;
                                next_sentCnt = sentCnt + 8'h01;
                            end
                        end else begin
                            next_state = ST_IGNORE;
                        end
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    next_sdaOeN = 1'b1;
                end
            endcase
        end
        // Masked merge keeps reserved and read-only bits
        if (wrEn && ptr < 7'(REG_COUNT)) begin
            next_regs[ptr[3:0]] = (regs[ptr[3:0]] & ~WRITE_MASK[ptr[3:0]]) |
                                  (shiftReg & WRITE_MASK[ptr[3:0]]);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            phase     <= PH_ADDR;
            bitCnt    <= 3'h0;
            shiftReg  <= 8'h00;
            byteDone  <= 1'b0;
            readMode  <= 1'b0;
            blockMode <= 1'b0;
            countSeen <= 1'b0;
            ptr       <= 7'h00;
            sentCnt   <= 8'h00;
            acked     <= 1'b0;
            sdaOeN    <= 1'b1;
            sdaOut    <= 1'b0;
            regs      <= RESET_VALUE;
        end else begin
            state     <= next_state;
            phase     <= next_phase;
            bitCnt    <= next_bitCnt;
            shiftReg  <= next_shiftReg;
            byteDone  <= next_byteDone;
            readMode  <= next_readMode;
            blockMode <= next_blockMode;
            countSeen <= next_countSeen;
            ptr       <= next_ptr;
            sentCnt   <= next_sentCnt;
            acked     <= next_acked;
            sdaOeN    <= next_sdaOeN;
            sdaOut    <= 1'b0;
            regs      <= next_regs;
        end
    end

    // ****************************************
    // Control outputs, taken from register bits
    // ****************************************
    assign spreadProfileSelect    = regs[IDX_PROFILE][PROFILE_BIT];
    assign refoutEnable           = {regs[IDX_ENABLE][OE4_BIT], regs[IDX_ENABLE][OE3_BIT],
                                     regs[IDX_ENABLE][OE2_BIT], regs[IDX_ENABLE][OE1_BIT]};
    assign spreadModulationEnable = regs[IDX_ENABLE][SPREAD_EN_BIT];
    assign testModeSelect         = regs[IDX_TEST][TEST_SEL_BIT];
    assign testModeEntry          = regs[IDX_TEST][TEST_ENTRY_BIT];
    assign outputSwingCode        = regs[IDX_TEST][SWING_MSB:0];
    assign secondGenCompliant     = regs[IDX_COMPLY][COMPLY_BIT];

    // ****************************************
    // Checks
    // ****************************************
    sequence sCountLoad;
        state == ST_RX_ACK && sclFall && !stopCond && !startCond &&
        readMode && blockMode && !countSeen;
    endsequence
    sequence sIdentWrite;
        wrEn && ptr == 7'(IDX_IDENT);
    endsequence

    chk_profile_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrEn && ptr == 7'(IDX_PROFILE) |=> spreadProfileSelect == $past(shiftReg[6]))
        else $error("Spread profile bit not updated");
    chk_refout_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrEn && ptr == 7'(IDX_ENABLE) |=>
        refoutEnable == {$past(shiftReg[2]), $past(shiftReg[3]),
                         $past(shiftReg[5]), $past(shiftReg[6])})
        else $error("Output enables not updated");
    chk_spread_enable: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrEn && ptr == 7'(IDX_ENABLE) |=> spreadModulationEnable == $past(shiftReg[1]))
        else $error("Spread enable not updated");
    chk_test_fields: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrEn && ptr == 7'(IDX_TEST) |=>
        {testModeSelect, testModeEntry, outputSwingCode} == $past(shiftReg[4:0]))
        else $error("Test and swing fields not updated");
    chk_comply_fixed: assert property (@(posedge ref_clk) disable iff (!rstn)
        secondGenCompliant) else $error("Compliance flag cleared");
    chk_count_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
        sCountLoad |=> state == ST_TX_BYTE && shiftReg == $past(regs[IDX_COUNT]) ##1
        countSeen)
        else $error("Block read count byte wrong");
    chk_addr_refuse: assert property (@(posedge ref_clk) disable iff (!rstn)
        state == ST_RX_BYTE && phase == PH_ADDR && byteDone && sclFall && !stopCond &&
        !startCond && shiftReg[7:1] != SLAVE_ADDR |=> state == ST_IGNORE && sdaOeN)
        else $error("Foreign address acknowledged");
    chk_cmd_pointer: assert property (@(posedge ref_clk) disable iff (!rstn)
        state == ST_RX_BYTE && phase == PH_CMD && byteDone && sclFall && !stopCond &&
        !startCond |=> ptr == ($past(shiftReg[7]) ? $past(shiftReg[6:0]) : 7'h00))
        else $error("Command pointer wrong");
    chk_ident_fixed: assert property (@(posedge ref_clk) disable iff (!rstn)
        sIdentWrite |=> regs[IDX_IDENT] == {REV_CODE, MAKER_CODE})
        else $error("Identity byte changed");
    chk_reserved_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrEn && ptr == 7'(IDX_PROFILE) |=>
        (regs[IDX_PROFILE] & 8'hBF) == ($past(regs[IDX_PROFILE]) & 8'hBF))
        else $error("Reserved bits changed by write");
    chk_ptr_ascend: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrEn |=> ptr == $past(ptr) + 7'h01) else $error("Block pointer did not advance");

endmodule

// file: bench/cgr_host_model.sv
// Two-wire bus host model facing the register bank serial port
`timescale 1ns/1ps
module cgr_host_model #(
    parameter int HALF = 20
) (
    // Clock
    input  wire logic       ref_clk,
    // Bus lines, data released high by the pull-up
    input  wire logic       sdaWire,
    output logic            sclPin,
    output logic            hostSda,
    // Finished byte: {acked or read, byte}
    output logic [8:0]      resVal,
    output logic            resStrobe
);
    initial begin
        sclPin    = 1'b1;
        hostSda   = 1'b1;
        resVal    = 9'h000;
        resStrobe = 1'b0;
    end

    task automatic waitc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Data moves two cycles after the clock fall, so hold time is kept
    task automatic bitx(input logic tx, output logic rx);
        waitc(2);
        hostSda = tx;
        waitc(HALF);
        sclPin = 1'b1;
        waitc(HALF);
        rx = sdaWire;
        sclPin = 1'b0;
    endtask

    // Also serves as repeated start; clock stands still between frames
    task automatic start();
        waitc(2);
        hostSda = 1'b1;
        waitc(HALF);
        sclPin = 1'b1;
        waitc(HALF);
        hostSda = 1'b0;
        waitc(HALF);
        sclPin = 1'b0;
    endtask

    task automatic stop();
        waitc(2);
        hostSda = 1'b0;
        waitc(HALF);
        sclPin = 1'b1;
        waitc(HALF);
        hostSda = 1'b1;
        waitc(HALF);
    endtask

    // Whole bytes only; a tx of FF leaves the line to the device
    task automatic xfer(input logic [7:0] tx, input logic last, input logic isRead);
        logic [7:0] rx;
        logic       nine;
        for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], rx[i]);
        end
        bitx(last, nine);
        resVal = isRead ? {1'b1, rx} : {~nine, tx};
        resStrobe = 1'b1;
        waitc(1);
        resStrobe = 1'b0;
    endtask
endmodule

// file: bench/cgr_ctrl_regs_test.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
module cgr_ctrl_regs_test
    import cgr_pkg::*;
;
    // ****
    // Signals
    // ****
    logic        ref_clk;
    logic        rstn;
    logic        sclPin;
    logic        hostSda;
    wire logic   sdaWire;
    logic        sdaOut;
    logic        sdaOeN;
    logic [3:0]  refoutEnable;
    logic        spreadModulationEnable;
    logic        spreadProfileSelect;
    logic        testModeSelect;
    logic        testModeEntry;
    logic [2:0]  outputSwingCode;
    logic        secondGenCompliant;
    logic [8:0]  resVal;
    logic        resStrobe;
    logic [7:0]  shadow [REG_COUNT];
    logic [8:0]  expQ [$];
    int          n_fail = 0;
    int          checks = 0;
    int          seed;
    int          idxList [6] = '{1, 4, 9, 11, 0, 7};

    // Open drain data line with pull-up
    assign sdaWire = hostSda & (sdaOeN | sdaOut);

    cgr_ctrl_regs cgr_ctrl_regs_inst (
        .ref_clk                (ref_clk),
        .rstn                   (rstn),
        .sclPin                 (sclPin),
        .sdaIn                  (sdaWire),
        .sdaOut                 (sdaOut),
        .sdaOeN                 (sdaOeN),
        .refoutEnable           (refoutEnable),
        .spreadModulationEnable (spreadModulationEnable),
        .spreadProfileSelect    (spreadProfileSelect),
        .testModeSelect         (testModeSelect),
        .testModeEntry          (testModeEntry),
        .outputSwingCode        (outputSwingCode),
        .secondGenCompliant     (secondGenCompliant)
    );

    cgr_host_model cgr_host_model_inst (
        .ref_clk   (ref_clk),
        .sdaWire   (sdaWire),
        .sclPin    (sclPin),
        .hostSda   (hostSda),
        .resVal    (resVal),
        .resStrobe (resStrobe)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ****
    // Checking
    // ****
    task automatic cmpRes(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpOut(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge ref_clk) begin
        if (resStrobe === 1'b1) begin
            if (expQ.size() > 0)
                cmpRes(resVal, expQ.pop_front());
            else begin
                n_fail++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, resVal, 9'h000);
            end
        end
    end

    task automatic checkOuts();
        cmpOut({refoutEnable, spreadModulationEnable, spreadProfileSelect, testModeSelect,
                testModeEntry, outputSwingCode, secondGenCompliant},
               {shadow[4][2], shadow[4][3], shadow[4][5], shadow[4][6], shadow[4][1],
                shadow[1][6], shadow[9][4], shadow[9][3], shadow[9][2:0],
                shadow[11][1]});
    endtask

    task automatic give_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****
    // Bus operations
    // ****
    task automatic put(input logic [7:0] b, input logic ack);
        expQ.push_back({ack, b});
        cgr_host_model_inst.xfer(b, 1'b1, 1'b0);
    endtask

    task automatic get(input logic [7:0] e, input logic last);
        expQ.push_back({1'b1, e});
        cgr_host_model_inst.xfer(8'hFF, last, 1'b1);
    endtask

    // Only masked bits take the new value
    task automatic merge(input int idx, input logic [7:0] v);
        shadow[idx] = (shadow[idx] & ~WRITE_MASK[idx]) | (v & WRITE_MASK[idx]);
    endtask

    task automatic regWrite(input int idx, input logic [7:0] v);
        cgr_host_model_inst.start();
        put({SLAVE_ADDR, 1'b0}, 1'b1);
        put({1'b1, 7'(idx)}, 1'b1);
        put(v, 1'b1);
        cgr_host_model_inst.stop();
        merge(idx, v);
    endtask

    task automatic regRead(input int idx);
        cgr_host_model_inst.start();
        put({SLAVE_ADDR, 1'b0}, 1'b1);
        put({1'b1, 7'(idx)}, 1'b1);
        cgr_host_model_inst.start();
        put({SLAVE_ADDR, 1'b1}, 1'b1);
        get(shadow[idx], 1'b1);
        cgr_host_model_inst.stop();
    endtask

    // Past the count the device lets go, so the pull-up reads FF
    task automatic blockRead(input int n);
        logic [7:0] e;
        cgr_host_model_inst.start();
        put({SLAVE_ADDR, 1'b0}, 1'b1);
        put(8'h00, 1'b1);
        cgr_host_model_inst.start();
        put({SLAVE_ADDR, 1'b1}, 1'b1);
        get(shadow[IDX_COUNT], 1'b0);
        for (int i = 0; i < n; i++) begin
            e = (i >= shadow[IDX_COUNT]) ? 8'hFF : (i < REG_COUNT) ? shadow[i] : 8'h00;
            get(e, i == n - 1);
        end
        cgr_host_model_inst.stop();
    endtask

    // ****
    // Sequence
    // ****
    initial begin
        seed = 32'hE021;
        rstn = 1'b0;
        foreach (shadow[i]) shadow[i] = RESET_VALUE[i];
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        checkOuts();
        repeat (5) @(negedge ref_clk);
        blockRead(14);
        for (int i = 0; i < 8; i++) begin
            regWrite(idxList[i % 6], 8'($random(seed)));
            regRead(idxList[i % 6]);
            checkOuts();
        end
        for (int c = 0; c < 8; c++) begin
            regWrite(IDX_TEST, {5'($random(seed)), 3'(c)});
            checkOuts();
        end
        cgr_host_model_inst.start();
        put({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
        put({1'b1, 7'(IDX_ENABLE)}, 1'b0);
        put(8'h00, 1'b0);
        cgr_host_model_inst.stop();
        checkOuts();
        cgr_host_model_inst.start();
        put({SLAVE_ADDR, 1'b0}, 1'b1);
        put(8'h00, 1'b1);
        put(8'h02, 1'b1);
        put(8'hFF, 1'b1);
        put(~shadow[1], 1'b1);
        cgr_host_model_inst.stop();
        merge(1, ~shadow[1]);
        checkOuts();
        regWrite(IDX_COUNT, 8'h03);
        blockRead(4);
        rstn = 1'b0;
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        foreach (shadow[i]) shadow[i] = RESET_VALUE[i];
        checkOuts();
        repeat (5) @(negedge ref_clk);
        regRead(IDX_COUNT);
        repeat (20) @(negedge ref_clk);
        if (expQ.size() != 0) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 0, expQ.size());
        end
        give_verdict();
    end

    // Run needs some 50000 cycles; this allows about 90000
    initial begin
        #3_600_000;
        n_fail++;
        give_verdict();
    end
endmodule
